// >>> bench/adc_calibration_config_status_test.sv
`timescale 1ns/1ps
module adc_calibration_config_status_test;
  logic clk_sys;
  logic reset;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [7:0] reg_rdata;
  logic sample_valid;
  logic [8:0] primary_sample;
  logic [8:0] spare_sample;
  logic [9:0] offset_correction;
  logic irq;
  int err_count;
  int comparisons;

  adc_cal_control adc_cal_control_inst (
    .clk_sys(clk_sys),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .sample_valid(sample_valid),
    .primary_sample(primary_sample),
    .spare_sample(spare_sample),
    .offset_correction(offset_correction),
    .irq(irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic give_verdict;
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_corr(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t correction %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_irq(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t irq %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // bounded poll of the status register
  task automatic wait_status(input logic [7:0] m, input logic [7:0] v, output logic [7:0] d);
    int n;
    n = 0;
    rd(8'h6A, d);
    while ((d & m) !== v && n < 80) begin
      rd(8'h6A, d);
      n++;
    end
    if (n >= 80) begin
      err_count++;
      $display("ERROR %0t status wait ran out", $time);
    end
  endtask

  // hold the sequencer and drop stale events
  task automatic stop_cal;
    logic [7:0] d;
    wr(8'h61, 8'h00);
    rd(8'h70, d);
  endtask

  task automatic test_reset_values;
    logic [7:0] d;
    rd(8'h65, d);
    chk_reg(d, 8'h01);
    rd(8'h68, d);
    chk_reg(d, 8'h61);
    rd(8'h6B, d);
    chk_reg(d, 8'h00);
    rd(8'h62, d);
    chk_reg(d, 8'h01);
    rd(8'h7F, d);
    chk_reg(d, 8'h00);
  endtask

  // write then read in the very next cycle, then data must fall back
  task automatic test_back_to_back;
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= 8'h68;
    reg_wdata <= 8'h35;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    chk_reg(reg_rdata, 8'h35);
    @(posedge clk_sys);
    #1;
    chk_reg(reg_rdata, 8'h00);
  endtask

  task automatic test_midcode;
    logic [7:0] d;
    stop_cal();
    wr(8'h68, 8'h00);
    wr(8'h62, 8'h01);
    wr(8'h65, 8'h01);
    wr(8'h71, 8'h00);
    primary_sample <= 9'h104;
    spare_sample <= 9'h0F0;
    wr(8'h61, 8'h01);
    wait_status(8'h03, 8'h03, d);
    chk_reg(d, 8'h17);
    chk_corr(offset_correction, 10'h3FC);
    chk_irq(irq, 1'b0);
    wr(8'h71, 8'h03);
    #1;
    chk_irq(irq, 1'b1);
    rd(8'h70, d);
    chk_reg(d, 8'h03);
    chk_irq(irq, 1'b0);
    wr(8'h6A, 8'hFF);
    rd(8'h6A, d);
    chk_reg(d, 8'h17);
  endtask

  task automatic test_skip;
    logic [7:0] d;
    stop_cal();
    rd(8'h6A, d);
    chk_reg(d & 8'h03, 8'h00);
    wr(8'h62, 8'h00);
    wr(8'h61, 8'h01);
    wait_status(8'h03, 8'h03, d);
    chk_reg(d, 8'h17);
  endtask

  // spare reference is only legal with background enabled, set first
  task automatic test_spare_halt;
    logic [7:0] d;
    stop_cal();
    wr(8'h68, 8'h10);
    wr(8'h62, 8'h03);
    wr(8'h65, 8'h05);
    wr(8'h71, 8'h04);
    primary_sample <= 9'h104;
    spare_sample <= 9'h102;
    wr(8'h61, 8'h01);
    wait_status(8'h1F, 8'h0D, d);
    chk_reg(d, 8'h0D);
    chk_corr(offset_correction, 10'h3FE);
    wr(8'h72, 8'h01);
    wait_status(8'h1F, 8'h13, d);
    chk_reg(d, 8'h13);
    wr(8'h72, 8'h00);
    wait_status(8'h02, 8'h00, d);
    chk_reg(d & 8'hE3, 8'h01);
    chk_irq(irq, 1'b1);
    rd(8'h70, d);
    chk_reg(d, 8'h07);
    chk_irq(irq, 1'b0);
    stop_cal();
  endtask

  initial begin
    #2000000;
    err_count++;
    give_verdict();
  end

  initial begin
    err_count = 0;
    comparisons = 0;
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    sample_valid = 1'b1;
    primary_sample = 9'h100;
    spare_sample = 9'h100;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    test_reset_values();
    test_back_to_back();
    test_midcode();
    test_skip();
    test_spare_halt();
    give_verdict();
  end
endmodule

// >>> design/adc_cal_consts.svh
// Contract
// - offset reference select 0: offsets calibrated against mid-code, toward zero offset
// - offset reference select 1: primary offsets matched to spare converter samples
// - offset averaging field bits 6:4, reset 0x6, larger means more averaging
// - linearity averaging field bits 2:0, reset 0x1, larger means more averaging
// - status register read-only; bits 4:2 status code, bits 7:5 read zero
// - background-halted bit 1 set once background calibration stops at requested phase
// - background-halted bit cleared as soon as calibration resumes
// - background disabled: halted bit set when foreground finishes or is skipped
// - foreground-complete bit 0 high after foreground completes or is skipped
// - background calibration enable bit: 1 enables, 0 disables
`ifndef ADC_CAL_CONSTS_SVH
`define ADC_CAL_CONSTS_SVH

`define ADDR_CAL_RUN 8'h61
`define ADDR_CFG_ZERO 8'h62
`define ADDR_CFG_ONE 8'h65
`define ADDR_AVG 8'h68
`define ADDR_STATE 8'h6A
`define ADDR_PIN 8'h6B
`define ADDR_INT_STATUS 8'h70
`define ADDR_INT_MASK 8'h71
`define ADDR_HALT_REQ 8'h72

`define RST_CAL_RUN 8'h01
`define RST_CFG_ZERO 8'h01
`define RST_CFG_ONE 8'h01
`define RST_AVG 8'h61
`define RST_PIN 8'h00
`define RST_HALT_REQ 8'h00
`define RST_INT 3'h0

`define RUN_BIT 0
`define FG_BIT 0
`define BG_BIT 1
`define REF_SEL_BIT 2
`define HALT_BIT 0
`define OFFSET_AVG_HI 6
`define OFFSET_AVG_LO 4
`define LIN_AVG_HI 2
`define LIN_AVG_LO 0

`define INT_FG_COMPLETE 0
`define INT_HALTED 1
`define INT_RESUMED 2

`define MIDCODE 9'h100
`define LIN_SHIFT 4'h2

`endif

// >>> design/adc_cal_control.sv
`timescale 1ns/1ps
`include "adc_cal_consts.svh"
module adc_cal_control (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic [8:0] primary_sample,
  input wire logic [8:0] spare_sample,
  output logic [9:0] offset_correction,
  output logic irq
);

  logic [7:0] run_reg, next_run_reg;
  logic [7:0] cfg_zero, next_cfg_zero;
  logic [7:0] calibration_config_one, next_calibration_config_one;
  logic [7:0] averaging_control, next_averaging_control;
  logic [7:0] calibration_pin_setup, next_calibration_pin_setup;
  logic [7:0] halt_reg, next_halt_reg;
  logic [2:0] int_status, next_int_status;
  logic [2:0] int_mask, next_int_mask;
  logic [7:0] next_rdata;
  logic prev_done, prev_halted;
  logic [2:0] events;
  adc_cal_pkg::cal_settings_t settings;
  adc_cal_pkg::cal_status_t status;
  logic [7:0] calibration_state_flags;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  assign settings.run = run_reg[`RUN_BIT];
  assign settings.fg_enable = cfg_zero[`FG_BIT];
  assign settings.background_cal_enable = cfg_zero[`BG_BIT];
  assign settings.halt_request = halt_reg[`HALT_BIT];
  // spare reference with background off is left to software to avoid
  assign settings.offset_reference_select = calibration_config_one[`REF_SEL_BIT];
  assign settings.offset_averaging = averaging_control[`OFFSET_AVG_HI:`OFFSET_AVG_LO];
  assign settings.linearity_averaging = averaging_control[`LIN_AVG_HI:`LIN_AVG_LO];

  cal_sequencer cal_sequencer_inst (
    .clk_sys(clk_sys),
    .reset(reset),
    .settings(settings),
    .sample_valid(sample_valid),
    .primary_sample(primary_sample),
    .spare_sample(spare_sample),
    .status(status),
    .offset_correction(offset_correction)
  );

  // reserved upper bits forced to zero
  assign calibration_state_flags = {3'h0, status};

  // register writes; the status address has no write path at all
  always_comb begin
    next_run_reg = run_reg;
    next_cfg_zero = cfg_zero;
    next_calibration_config_one = calibration_config_one;
    next_averaging_control = averaging_control;
    next_calibration_pin_setup = calibration_pin_setup;
    next_halt_reg = halt_reg;
    next_int_mask = int_mask;
    if (reg_write) begin
      if (hit(reg_addr, `ADDR_CAL_RUN)) begin
        next_run_reg = reg_wdata;
      end
      if (hit(reg_addr, `ADDR_CFG_ZERO)) begin
        next_cfg_zero = reg_wdata;
      end
      if (hit(reg_addr, `ADDR_CFG_ONE)) begin
        next_calibration_config_one = reg_wdata;
      end
      if (hit(reg_addr, `ADDR_AVG)) begin
        next_averaging_control = reg_wdata;
      end
      if (hit(reg_addr, `ADDR_PIN)) begin
        next_calibration_pin_setup = reg_wdata;
      end
      if (hit(reg_addr, `ADDR_HALT_REQ)) begin
        next_halt_reg = reg_wdata;
      end
      if (hit(reg_addr, `ADDR_INT_MASK)) begin
        next_int_mask = reg_wdata[2:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      run_reg <= `RST_CAL_RUN;
      cfg_zero <= `RST_CFG_ZERO;
      calibration_config_one <= `RST_CFG_ONE;
      averaging_control <= `RST_AVG;
      calibration_pin_setup <= `RST_PIN;
      halt_reg <= `RST_HALT_REQ;
      int_mask <= `RST_INT;
    end else begin
      run_reg <= next_run_reg;
      cfg_zero <= next_cfg_zero;
      calibration_config_one <= next_calibration_config_one;
      averaging_control <= next_averaging_control;
      calibration_pin_setup <= next_calibration_pin_setup;
      halt_reg <= next_halt_reg;
      int_mask <= next_int_mask;
    end
  end

  // events from flag edges; resume only counts while calibration still runs
  assign events[`INT_FG_COMPLETE] = status.foreground_complete && !prev_done;
  assign events[`INT_HALTED] = status.background_halted && !prev_halted;
  assign events[`INT_RESUMED] = !status.background_halted && prev_halted && settings.run;

  // a read clears the sticky bits, but an event in that cycle survives
  always_comb begin
    next_int_status = int_status;
    if (reg_read && hit(reg_addr, `ADDR_INT_STATUS)) begin
      next_int_status = `RST_INT;
    end
    next_int_status = next_int_status | events;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      int_status <= `RST_INT;
      prev_done <= 1'b0;
      prev_halted <= 1'b0;
    end else begin
      int_status <= next_int_status;
      prev_done <= status.foreground_complete;
      prev_halted <= status.background_halted;
    end
  end

  assign irq = |(int_status & int_mask);

  // read data valid only in the cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = 8'h00;
    if (reg_read) begin
      case (reg_addr)
        `ADDR_CAL_RUN: next_rdata = run_reg;
        `ADDR_CFG_ZERO: next_rdata = cfg_zero;
        `ADDR_CFG_ONE: next_rdata = calibration_config_one;
        `ADDR_AVG: next_rdata = averaging_control;
        `ADDR_STATE: next_rdata = calibration_state_flags;
        `ADDR_PIN: next_rdata = calibration_pin_setup;
        `ADDR_INT_STATUS: next_rdata = {5'h00, int_status};
        `ADDR_INT_MASK: next_rdata = {5'h00, int_mask};
        `ADDR_HALT_REQ: next_rdata = halt_reg;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_avg_reset_value: assert property (
    $fell(reset) |-> averaging_control == `RST_AVG &&
                     settings.offset_averaging == 3'h6 && settings.linearity_averaging == 3'h1)
    else $error("averaging reset values wrong");

  chk_offset_averaging_write: assert property (
    reg_write && hit(reg_addr, `ADDR_AVG)
    |=> settings.offset_averaging == $past(reg_wdata[`OFFSET_AVG_HI:`OFFSET_AVG_LO]))
    else $error("offset averaging not taken from bits 6:4");

  chk_lin_avg_write: assert property (
    reg_write && hit(reg_addr, `ADDR_AVG)
    |=> settings.linearity_averaging == $past(reg_wdata[`LIN_AVG_HI:`LIN_AVG_LO]))
    else $error("linearity averaging not taken from bits 2:0");

  chk_status_read: assert property (
    reg_read && hit(reg_addr, `ADDR_STATE)
    |=> reg_rdata[7:5] == 3'h0 && reg_rdata[4:2] == $past(status.code) &&
        reg_rdata[1:0] == $past({status.background_halted, status.foreground_complete}))
    else $error("status read layout wrong");

  chk_bg_enable_write: assert property (
    reg_write && hit(reg_addr, `ADDR_CFG_ZERO)
    |=> settings.background_cal_enable == $past(reg_wdata[`BG_BIT]))
    else $error("background enable not taken from write");

  chk_ro_write_ignored: assert property (
    reg_write && hit(reg_addr, `ADDR_STATE)
    |=> $stable(run_reg) && $stable(cfg_zero) && $stable(calibration_config_one) &&
        $stable(averaging_control) && $stable(calibration_pin_setup) && $stable(halt_reg))
    else $error("write to status address disturbed a register");

  chk_event_beats_clear: assert property (
    reg_read && hit(reg_addr, `ADDR_INT_STATUS) && events != 3'h0
    |=> int_status == $past(events))
    else $error("event lost against read clear");

  chk_irq_follows: assert property (
    (events & int_mask) != 3'h0 && !(reg_write && hit(reg_addr, `ADDR_INT_MASK)) |=> irq)
    else $error("interrupt not raised for unmasked status");

  cov_fg_complete: cover property ($rose(status.foreground_complete));
  cov_halted: cover property ($rose(status.background_halted) && settings.background_cal_enable);
  cov_resumed: cover property (events[`INT_RESUMED]);
  cov_irq: cover property ($rose(irq));

endmodule

// >>> design/adc_cal_pkg.sv
package adc_cal_pkg;

  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_LINEARITY = 3'b001,
    ST_OFFSET = 3'b010,
    ST_BACKGROUND = 3'b011,
    ST_HALTED = 3'b100,
    ST_DONE = 3'b101
  } cal_state_t;

  typedef struct packed {
    logic run;
    logic fg_enable;
    logic background_cal_enable;
    logic halt_request;
    logic offset_reference_select;
    logic [2:0] offset_averaging;
    logic [2:0] linearity_averaging;
  } cal_settings_t;

  typedef struct packed {
    logic [2:0] code;
    logic background_halted;
    logic foreground_complete;
  } cal_status_t;

endpackage

// >>> design/cal_sequencer.sv
`timescale 1ns/1ps
`include "adc_cal_consts.svh"
module cal_sequencer (
  input wire logic clk_sys,
  input wire logic reset,
  input wire adc_cal_pkg::cal_settings_t settings,
  input wire logic sample_valid,
  input wire logic [8:0] primary_sample,
  input wire logic [8:0] spare_sample,
  output adc_cal_pkg::cal_status_t status,
  output logic [9:0] offset_correction
);

  adc_cal_pkg::cal_state_t state, next_state;
  logic [9:0] cnt, next_cnt;
  logic signed [17:0] acc, next_acc;
  logic [9:0] next_corr;
  logic fg_complete, next_fg_complete;
  logic stopped, next_stopped;
  logic [8:0] ref_code;
  logic signed [17:0] err;
  logic signed [17:0] sum_now;
  logic [9:0] os_len;
  logic [9:0] lin_len;
  logic window_end;

  function automatic logic [9:0] window_len(input logic [2:0] avg);
    window_len = 10'h001 << avg;
  endfunction

  function automatic logic [9:0] neg_average(input logic signed [17:0] sum,
                                             input logic [2:0] avg);
    logic signed [17:0] q;
    q = sum >>> avg;
    neg_average = 10'(-q);
  endfunction

  // reference: mid-code, or the spare converter samples that the primary is matched against
  assign ref_code = settings.offset_reference_select ? spare_sample : `MIDCODE;
  assign err = $signed({9'h000, primary_sample}) - $signed({9'h000, ref_code});
  assign sum_now = acc + err;
  assign os_len = window_len(settings.offset_averaging);
  assign lin_len = window_len(settings.linearity_averaging) << `LIN_SHIFT;
  assign window_end = sample_valid && (cnt == os_len - 10'h001);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_acc = acc;
    next_corr = offset_correction;
    next_fg_complete = fg_complete;
    next_stopped = stopped;
    if (!settings.run) begin
      next_state = adc_cal_pkg::ST_HOLD;
      next_cnt = 10'h000;
      next_acc = 18'h00000;
      next_corr = 10'h000;
      next_fg_complete = 1'b0;
      next_stopped = 1'b0;
    end else begin
      case (state)
        adc_cal_pkg::ST_HOLD: begin
          if (settings.fg_enable) begin
            next_state = adc_cal_pkg::ST_LINEARITY;
          end else begin
            next_fg_complete = 1'b1;
            if (settings.background_cal_enable) begin
              next_state = adc_cal_pkg::ST_BACKGROUND;
            end else begin
              next_state = adc_cal_pkg::ST_DONE;
              next_stopped = 1'b1;
            end
          end
        end
        adc_cal_pkg::ST_LINEARITY: begin
          if (cnt == lin_len - 10'h001) begin
            next_state = adc_cal_pkg::ST_OFFSET;
            next_cnt = 10'h000;
          end else begin
            next_cnt = cnt + 10'h001;
          end
        end
        adc_cal_pkg::ST_OFFSET: begin
          if (window_end) begin
            next_corr = neg_average(sum_now, settings.offset_averaging);
            next_acc = 18'h00000;
            next_cnt = 10'h000;
            next_fg_complete = 1'b1;
            if (settings.background_cal_enable) begin
              next_state = adc_cal_pkg::ST_BACKGROUND;
            end else begin
              next_state = adc_cal_pkg::ST_DONE;
              next_stopped = 1'b1;
            end
          end else if (sample_valid) begin
            next_acc = sum_now;
            next_cnt = cnt + 10'h001;
          end
        end
        adc_cal_pkg::ST_BACKGROUND: begin
          if (!settings.background_cal_enable) begin
            next_state = adc_cal_pkg::ST_DONE;
            next_stopped = 1'b1;
            next_acc = 18'h00000;
            next_cnt = 10'h000;
          end else if (window_end) begin
            next_corr = neg_average(sum_now, settings.offset_averaging);
            next_acc = 18'h00000;
            next_cnt = 10'h000;
            // halts only at a window boundary so the trim is never half-averaged
            if (settings.halt_request) begin
              next_state = adc_cal_pkg::ST_HALTED;
              next_stopped = 1'b1;
            end
          end else if (sample_valid) begin
            next_acc = sum_now;
            next_cnt = cnt + 10'h001;
          end
        end
        adc_cal_pkg::ST_HALTED: begin
          if (!settings.background_cal_enable) begin
            next_state = adc_cal_pkg::ST_DONE;
          end else if (!settings.halt_request) begin
            next_state = adc_cal_pkg::ST_BACKGROUND;
            next_stopped = 1'b0;
          end
        end
        adc_cal_pkg::ST_DONE: begin
          if (settings.background_cal_enable) begin
            next_state = adc_cal_pkg::ST_BACKGROUND;
            next_stopped = 1'b0;
          end
        end
        default: begin
          next_state = adc_cal_pkg::ST_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= adc_cal_pkg::ST_HOLD;
      cnt <= 10'h000;
      acc <= 18'h00000;
      offset_correction <= 10'h000;
      fg_complete <= 1'b0;
      stopped <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      acc <= next_acc;
      offset_correction <= next_corr;
      fg_complete <= next_fg_complete;
      stopped <= next_stopped;
    end
  end

  assign status.code = state;
  assign status.background_halted = stopped;
  assign status.foreground_complete = fg_complete;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_ref_midcode: assert property (
    settings.run && sample_valid && cnt == 10'h000 && settings.offset_averaging != 3'h0 &&
    !settings.offset_reference_select &&
    (state == adc_cal_pkg::ST_OFFSET ||
     (state == adc_cal_pkg::ST_BACKGROUND && settings.background_cal_enable))
    |=> acc == $signed({9'h000, $past(primary_sample)}) - $signed({9'h000, `MIDCODE}))
    else $error("offset error not taken against mid-code");

  chk_ref_spare: assert property (
    settings.run && sample_valid && cnt == 10'h000 && settings.offset_averaging != 3'h0 &&
    settings.offset_reference_select &&
    (state == adc_cal_pkg::ST_OFFSET ||
     (state == adc_cal_pkg::ST_BACKGROUND && settings.background_cal_enable))
    |=> acc == $signed({9'h000, $past(primary_sample)}) -
               $signed({9'h000, $past(spare_sample)}))
    else $error("offset error not taken against spare samples");

  chk_halt_set: assert property (
    settings.run && settings.background_cal_enable && settings.halt_request &&
    state == adc_cal_pkg::ST_BACKGROUND && window_end
    |=> stopped && state == adc_cal_pkg::ST_HALTED)
    else $error("halt not reported at window end");

  chk_halt_clear: assert property (
    settings.run && settings.background_cal_enable && !settings.halt_request &&
    state == adc_cal_pkg::ST_HALTED
    |=> !stopped && state == adc_cal_pkg::ST_BACKGROUND)
    else $error("halted flag kept after resume");

  chk_skip_flags: assert property (
    settings.run && !settings.fg_enable && !settings.background_cal_enable &&
    state == adc_cal_pkg::ST_HOLD
    |=> stopped && fg_complete)
    else $error("skip without background did not report halted and done");

  chk_fg_complete: assert property (
    settings.run && state == adc_cal_pkg::ST_OFFSET && window_end |=> fg_complete)
    else $error("foreground complete not raised");

endmodule
